// *** bench/dual_pwm_assertions.sv ***
// Purpose: port-level checks of the dual pulse-width driver
// Assumes: helpers shadow bus writes to predict readback
// Notes: reads are judged at the edge where waitrequest is low
`timescale 1ns/1ps
module dual_pwm_assertions
	import dual_pwm_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// register bus
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// pins
	input wire logic counterSyncInput,
	input wire logic convStart,
	input wire logic [1:0] firstOutputChannel,
	input wire logic [1:0] secondOutputChannel
);
	logic [4:0] ctrl_ff;
	logic [15:0] prd_ff;
	logic [31:0] first_channel_duty_ff;
	logic [31:0] second_channel_duty_ff;
	logic [15:0] compare_a_value_ff;
	logic [15:0] compare_b_value_ff;
	logic wr;
	logic rdDone;
	logic arr;
	logic socArmed;
	assign wr = write && !read;
	assign rdDone = read && !waitrequest;
	assign arr = ctrl_ff[CTRL_ARRANGE_BIT];
	assign socArmed = !arr && (ctrl_ff[CTRL_SOC_ZERO_BIT] || ctrl_ff[CTRL_SOC_PRD_BIT]);

	function automatic logic [31:0] mrg(input logic [31:0] old);
		for (int i = 0; i < 4; i++) begin
			if (byteenable[i])
				old[8*i+:8] = writedata[8*i+:8];
		end
		return old;
	endfunction

	function automatic logic [15:0] scale(input logic [31:0] d);
		return 16'((64'(d) * 64'({prd_ff, 16'h0000})) >> CMP_LSB);
	endfunction

	function automatic logic hit(input logic [7:0] x, input logic [7:0] a);
		return x[7:2] == a[7:2];
	endfunction

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctrl_ff <= CTRL_RESET;
			prd_ff <= PERIOD_RESET;
		end else if (wr && hit(address, ADDR_CTRL)) begin
			ctrl_ff <= 5'(mrg({27'h0, ctrl_ff}));
		end else if (wr && hit(address, ADDR_PERIOD)) begin
			prd_ff <= 16'(mrg({16'h0000, prd_ff}));
		end
	end

	// a period change alone leaves compares stale, as in the device
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			first_channel_duty_ff <= DUTY_RESET;
			second_channel_duty_ff <= DUTY_RESET;
			compare_a_value_ff <= CMP_RESET;
			compare_b_value_ff <= CMP_RESET;
		end else if (wr && hit(address, ADDR_DUTY_A)) begin
			first_channel_duty_ff <= mrg(first_channel_duty_ff);
			compare_a_value_ff <= scale(mrg(first_channel_duty_ff));
		end else if (wr && hit(address, ADDR_DUTY_B)) begin
			second_channel_duty_ff <= mrg(second_channel_duty_ff);
			compare_b_value_ff <= scale(mrg(second_channel_duty_ff));
		end
	end

	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	AST_WR_NOWAIT: assert property (wr |-> !waitrequest)
		else $error("write was stalled");
	AST_RD_ONEWAIT: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
		else $error("read wait state wrong");
	AST_CMP_A0: assert property (rdDone && hit(address, ADDR_CMP_A0)
		|-> readdata == {16'h0000, compare_a_value_ff}) else $error("compare A0 readback wrong");
	AST_CMP_A1: assert property (rdDone && hit(address, ADDR_CMP_A1)
		|-> readdata == {16'h0000, compare_a_value_ff}) else $error("compare A1 readback wrong");
	AST_CMP_B0: assert property (rdDone && hit(address, ADDR_CMP_B0)
		|-> readdata == {16'h0000, compare_b_value_ff}) else $error("compare B0 readback wrong");
	AST_MIRROR: assert property (rdDone && hit(address, ADDR_PRD_MIRROR)
		|-> readdata == {prd_ff, 16'h0000}) else $error("period mirror wrong");
	AST_CONV_SRC: assert property (convStart |-> $past(socArmed))
		else $error("conversion start without enabled trigger");
	AST_PARTNER_IDLE: assert property (!arr && !$past(arr)
		|-> firstOutputChannel[1] == 1'b0 && secondOutputChannel[1] == 1'b0)
		else $error("partner active in dual mode");
	AST_BB_EXCL: assert property (arr && $past(arr) && $past(arr, 2)
		|-> (firstOutputChannel & secondOutputChannel) == 2'b00)
		else $error("channels overlap in pair mode");

	COV_SOC: cover property (convStart);
	COV_PAIR: cover property (arr && firstOutputChannel[1]);
	COV_CMP_A1: cover property (rdDone && hit(address, ADDR_CMP_A1));
endmodule

// *** bench/gate_driver_model.sv ***
// Purpose: gate-driver stand-in that totals high time per window
// Assumes: a window starts with a one-cycle clear pulse
// Notes: overlap flag is sticky until the next clear
`timescale 1ns/1ps
module gate_driver_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// gate drives
	input wire logic [1:0] gateA,
	input wire logic [1:0] gateB,
	// measurement
	input wire logic clear,
	output logic [1:0][15:0] highA,
	output logic [1:0][15:0] highB,
	output logic overlap
);
	always_ff @(posedge core_clk) begin
		for (int i = 0; i < 2; i++) begin
			highA[i] <= (!rst_n || clear) ? 16'h0000 : highA[i] + 16'(gateA[i]);
			highB[i] <= (!rst_n || clear) ? 16'h0000 : highB[i] + 16'(gateB[i]);
		end
	end

	// both switches of one leg on together would short the supply
	always_ff @(posedge core_clk) begin
		overlap <= (!rst_n || clear) ? 1'b0 : overlap || |(gateA & gateB);
	end
endmodule

// *** bench/tb_dual_pwm_duty_driver.sv ***
// Purpose: self-checking bench of the dual pulse-width driver
// Assumes: writes take no wait, reads one wait state
// Notes: after a first pass at 0 and 00ffffff, duties come from an xorshift sequence and stay below one
`timescale 1ns/1ps
module tb_dual_pwm_duty_driver
	import dual_pwm_pkg::*;
;
	localparam int SW_DIV = 40;
	localparam logic [7:0] RST_ADDR [7] = '{ADDR_CTRL, ADDR_PERIOD, ADDR_PHASE1, ADDR_DUTY_A,
		ADDR_FALL1, ADDR_CMP_B0, ADDR_PRD_MIRROR};
	localparam logic [31:0] RST_VAL [7] = '{32'h2, 32'h64, 32'h0, 32'h0, 32'h0, 32'h0,
		32'h00640000};
	localparam logic [31:0] SOC_CTRL [4] = '{32'h1a, 32'h0a, 32'h12, 32'h02};
	localparam int SOC_EXP [4] = '{2, 1, 1, 0};
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'hf;
	logic counterSyncInput = 1'b0;
	logic clear = 1'b0;
	logic [31:0] readdata;
	logic waitrequest;
	logic convStart;
	logic [1:0] firstOutputChannel;
	logic [1:0] secondOutputChannel;
	logic [1:0][15:0] highA;
	logic [1:0][15:0] highB;
	logic overlap;
	logic mOverlap;
	logic [31:0] rng = 32'hfe0a38f9;
	int nSoc = 0;
	int mSoc;
	logic [15:0] mA [2];
	logic [15:0] mB [2];
	int n_fail = 0;
	int n_tests = 0;

	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) nSoc <= clear ? 0 : nSoc + int'(convStart);

	dual_pwm_duty_driver dut (.core_clk(core_clk), .rst_n(rst_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .counterSyncInput(counterSyncInput), .convStart(convStart),
		.firstOutputChannel(firstOutputChannel), .secondOutputChannel(secondOutputChannel));
	gate_driver_model gates (.core_clk(core_clk), .rst_n(rst_n), .gateA(firstOutputChannel),
		.gateB(secondOutputChannel), .clear(clear), .highA(highA), .highB(highB),
		.overlap(overlap));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic int cmpOf(input logic [31:0] d, input int p);
		return int'((longint'(d) * p) >>> 24);
	endfunction
	// triangle count passes each level below c twice, zero once
	function automatic int triHigh(input int c);
		return c == 0 ? 0 : 2 * c - 1;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkIn(input logic [31:0] got, input int lo, input int hi);
		n_tests++;
		if ((got >= 32'(lo) && got <= 32'(hi)) !== 1'b1) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h range=%h..%h", $time, got, lo, hi);
		end
	endtask
	task automatic xfer(input logic rd, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		address <= a;
		writedata <= d;
		byteenable <= be;
		read <= rd;
		write <= !rd;
		@(posedge core_clk iff !waitrequest);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b0, a, d, 4'hf, q);
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b1, a, 32'h0, 4'hf, q);
		chk(q, e);
	endtask
	task automatic measure(input int n);
		clear <= 1'b1;
		@(posedge core_clk);
		clear <= 1'b0;
		repeat (n) @(posedge core_clk);
		#1;
		for (int i = 0; i < 2; i++) begin
			mA[i] = highA[i];
			mB[i] = highB[i];
		end
		mSoc = nSoc;
		mOverlap = overlap;
		@(posedge core_clk);
	endtask
	task automatic final_report();
		$display("tests=%0d mismatches=%0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		logic [31:0] q;
		logic [31:0] q2;
		logic [31:0] dA;
		logic [31:0] dB;
		int p;
		int cA;
		int cB;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		foreach (RST_ADDR[i]) rdChk(RST_ADDR[i], RST_VAL[i]);
		rdChk(8'hfc, 32'h0);
		wr(ADDR_CMP_A0, 32'h1234);
		rdChk(ADDR_CMP_A0, 32'h0);
		p = SW_DIV / 2;
		wr(ADDR_PERIOD, 32'(p));
		rdChk(ADDR_PRD_MIRROR, 32'(p) << 16);
		for (int k = 0; k < 3; k++) begin
			rng = xs(rng);
			dA = (k == 0) ? 32'h0 : {8'h00, rng[23:0]};
			rng = xs(rng);
			dB = (k == 0) ? 32'h00ffffff : {8'h00, rng[23:0]};
			wr(ADDR_DUTY_A, dA);
			wr(ADDR_DUTY_B, dB);
			cA = cmpOf(dA, p);
			cB = cmpOf(dB, p);
			rdChk(ADDR_CMP_A0, 32'(cA));
			rdChk(ADDR_CMP_B0, 32'(cB));
			measure(2 * p);
			chk(32'(mA[0]), 32'(triHigh(cA)));
			chk(32'(mB[0]), 32'(triHigh(cB)));
			chk(32'(mA[1] + mB[1]), 32'h0);
		end
		xfer(1'b0, ADDR_DUTY_B, 32'h0000ab00, 4'h2, q);
		dB[15:8] = 8'hab;
		rdChk(ADDR_DUTY_B, dB);
		rdChk(ADDR_CMP_B0, 32'(cmpOf(dB, p)));
		foreach (SOC_CTRL[i]) begin
			wr(ADDR_CTRL, SOC_CTRL[i]);
			measure(2 * p);
			chk(32'(mSoc), 32'(SOC_EXP[i]));
		end
		wr(ADDR_PHASE0, 32'h7);
		wr(ADDR_CTRL, 32'h0);
		counterSyncInput <= 1'b1;
		@(posedge core_clk);
		rdChk(ADDR_COUNT, 32'h7);
		wr(ADDR_CTRL, 32'h2);
		xfer(1'b1, ADDR_COUNT, 32'h0, 4'hf, q);
		xfer(1'b1, ADDR_COUNT, 32'h0, 4'hf, q2);
		chk(32'(q[15:0] != q2[15:0]), 32'h1);
		counterSyncInput <= 1'b0;
		wr(ADDR_PHASE1, 32'h1);
		wr(ADDR_CTRL, 32'h3);
		wr(ADDR_RISE0, 32'h0);
		wr(ADDR_FALL0, 32'h4);
		wr(ADDR_RISE1, 32'h0);
		wr(ADDR_FALL1, 32'h0);
		rng = xs(rng);
		dA = 32'h00200000 + (rng % 32'h00900000);
		wr(ADDR_DUTY_A, dA);
		cA = cmpOf(dA, p);
		rdChk(ADDR_CMP_A0, 32'(cA));
		rdChk(ADDR_CMP_A1, 32'(cA));
		// let a zero event align the partner before the window opens
		repeat (p + 1) @(posedge core_clk);
		measure(p + 1);
		chk(32'(mA[0]), 32'(cA));
		chk(32'(mA[1]), 32'(cA));
		chk(32'(mB[1]), 32'(p + 1 - cA));
		chkIn(32'(mB[0]), p - 3 - cA, p - 2 - cA);
		chk(32'(mOverlap), 32'h0);
		xfer(1'b1, ADDR_COUNT, 32'h0, 4'hf, q);
		chk(32'(q[31:16]), 32'(q[15:0]));
		// partner as master: a new phase must not shift it at the zero event
		wr(ADDR_CTRL, 32'h7);
		wr(ADDR_PHASE1, 32'h5);
		repeat (p + 1) @(posedge core_clk);
		xfer(1'b1, ADDR_COUNT, 32'h0, 4'hf, q);
		chk(32'(q[31:16]), 32'(q[15:0]));
		final_report();
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		final_report();
	end
endmodule

bind dual_pwm_duty_driver dual_pwm_assertions chk_inst (.core_clk(core_clk), .rst_n(rst_n),
	.address(address), .read(read), .write(write), .writedata(writedata),
	.byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
	.counterSyncInput(counterSyncInput), .convStart(convStart),
	.firstOutputChannel(firstOutputChannel), .secondOutputChannel(secondOutputChannel));

// *** hdl/dual_pwm_duty_driver.sv ***
// Purpose: dual pulse-width driver fed by q24 duty fractions
// Assumes: single clock; registers over a word-aligned bus slave
// Notes: arrangement bit picks dual up-down or the buck-boost pair
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps

module dual_pwm_duty_driver
	import dual_pwm_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// avalon-mm slave
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// synchronisation from outside
	input wire logic counterSyncInput,
	// conversion start trigger
	output logic convStart,
	// gate outputs, index 0 first module, index 1 its partner
	output logic [1:0] firstOutputChannel,
	output logic [1:0] secondOutputChannel
);

	// software state
	logic [CTRL_WIDTH-1:0] ctrl_ff;
	logic [15:0] period_ff;
	logic [31:0] counterPeriodMirror_ff;
	logic [15:0] phase0_ff;
	logic [15:0] phase1_ff;
	logic [31:0] firstChannelDuty_ff;
	logic [31:0] secondChannelDuty_ff;
	logic [15:0] risingDelaySetting0_ff;
	logic [15:0] fallingDelaySetting0_ff;
	logic [15:0] risingDelaySetting1_ff;
	logic [15:0] fallingDelaySetting1_ff;
	logic [15:0] compareAValue0_ff;
	logic [15:0] compareBValue0_ff;
	logic [15:0] compareAValue1_ff;

	// bus handling
	logic readPending_ff;
	logic [31:0] readdata_ff;
	logic [31:0] readMux;
	logic writeTaken;
	logic [7:0] wordAddr;
	logic [15:0] nxt_period;

	// scaling
	logic [31:0] nxt_first_channel_duty;
	logic [31:0] nxt_second_channel_duty;
	logic [63:0] productA;
	logic [63:0] productB;
	logic [15:0] scaledA;
	logic [15:0] scaledB;

	// arrangement and module wiring
	arrangement_t arrangement;
	logic upDownMode;
	logic deadBandOn;
	logic partnerEnable;
	logic sync0;
	logic sync1;
	logic syncFromFirst;
	logic zero0;
	logic prd0;
	logic [15:0] counter0;
	logic [15:0] counter1;
	logic [15:0] compareB1;
	logic convStart_ff;

	// merge a write into an old value under byte enables
	function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal,
		input logic [31:0] newVal, input logic [3:0] lanes);
		logic [31:0] result;
		result = oldVal;
		for (int i = 0; i < 4; i++) begin
			if (lanes[i]) begin
				result[i*8 +: 8] = newVal[i*8 +: 8];
			end
		end
		return result;
	endfunction

	assign wordAddr = {address[7:2], 2'b00};

	// writes finish at once; reads wait one cycle for registered data
	assign waitrequest = read && !readPending_ff;
	assign writeTaken = write && !read;
	assign readdata = readdata_ff;

	// a read held past its answer starts a second access; masters must drop it
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			readPending_ff <= 1'b0;
		end else begin
			readPending_ff <= read && !readPending_ff;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			readdata_ff <= 32'h00000000;
		end else if (read && !readPending_ff) begin
			readdata_ff <= readMux;
		end
	end

	always_comb begin
		readMux = 32'h00000000;
		case (wordAddr)
			ADDR_CTRL: readMux = {27'h0, ctrl_ff};
			ADDR_PERIOD: readMux = {16'h0000, period_ff};
			ADDR_PHASE0: readMux = {16'h0000, phase0_ff};
			ADDR_PHASE1: readMux = {16'h0000, phase1_ff};
			ADDR_DUTY_A: readMux = firstChannelDuty_ff;
			ADDR_DUTY_B: readMux = secondChannelDuty_ff;
			ADDR_RISE0: readMux = {16'h0000, risingDelaySetting0_ff};
			ADDR_FALL0: readMux = {16'h0000, fallingDelaySetting0_ff};
			ADDR_RISE1: readMux = {16'h0000, risingDelaySetting1_ff};
			ADDR_FALL1: readMux = {16'h0000, fallingDelaySetting1_ff};
			ADDR_CMP_A0: readMux = {16'h0000, compareAValue0_ff};
			ADDR_CMP_B0: readMux = {16'h0000, compareBValue0_ff};
			ADDR_CMP_A1: readMux = {16'h0000, compareAValue1_ff};
			ADDR_COUNT: readMux = {counter1, counter0};
			ADDR_PRD_MIRROR: readMux = counterPeriodMirror_ff;
			default: readMux = 32'h00000000;
		endcase
	end

	// control register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctrl_ff <= CTRL_RESET;
		end else if (writeTaken && wordAddr == ADDR_CTRL && byteenable[0]) begin
			ctrl_ff <= writedata[CTRL_WIDTH-1:0];
		end
	end

	// 16-bit registers keep the low half; upper lanes of a write are dropped
	assign nxt_period = 16'(mergeBytes({16'h0000, period_ff}, writedata, byteenable));

	// period and its q16 copy; software supplies the halved figure itself
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			period_ff <= PERIOD_RESET;
			counterPeriodMirror_ff <= {PERIOD_RESET, 16'h0000};
		end else if (writeTaken && wordAddr == ADDR_PERIOD) begin
			period_ff <= nxt_period;
			counterPeriodMirror_ff <= {nxt_period, 16'h0000};
		end
	end

	// phase offsets, only meaningful for a slave module
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			phase0_ff <= PHASE_RESET;
			phase1_ff <= PHASE_RESET;
		end else if (writeTaken && wordAddr == ADDR_PHASE0) begin
			phase0_ff <= 16'(mergeBytes({16'h0000, phase0_ff}, writedata, byteenable));
		end else if (writeTaken && wordAddr == ADDR_PHASE1) begin
			phase1_ff <= 16'(mergeBytes({16'h0000, phase1_ff}, writedata, byteenable));
		end
	end

	// dead-band delays; reset leaves them at zero until software sets them
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			risingDelaySetting0_ff <= DELAY_RESET;
			fallingDelaySetting0_ff <= DELAY_RESET;
			risingDelaySetting1_ff <= DELAY_RESET;
			fallingDelaySetting1_ff <= DELAY_RESET;
		end else if (writeTaken) begin
			case (wordAddr)
				ADDR_RISE0: risingDelaySetting0_ff <= 16'(mergeBytes({16'h0000,
					risingDelaySetting0_ff}, writedata, byteenable));
				ADDR_FALL0: fallingDelaySetting0_ff <= 16'(mergeBytes({16'h0000,
					fallingDelaySetting0_ff}, writedata, byteenable));
				ADDR_RISE1: risingDelaySetting1_ff <= 16'(mergeBytes({16'h0000,
					risingDelaySetting1_ff}, writedata, byteenable));
				ADDR_FALL1: fallingDelaySetting1_ff <= 16'(mergeBytes({16'h0000,
					fallingDelaySetting1_ff}, writedata, byteenable));
				default: begin
				end
			endcase
		end
	end

	// duty values as they will stand after this cycle's write
	assign nxt_first_channel_duty = (writeTaken && wordAddr == ADDR_DUTY_A) ?
		mergeBytes(firstChannelDuty_ff, writedata, byteenable) : firstChannelDuty_ff;
	assign nxt_second_channel_duty = (writeTaken && wordAddr == ADDR_DUTY_B) ?
		mergeBytes(secondChannelDuty_ff, writedata, byteenable) : secondChannelDuty_ff;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			firstChannelDuty_ff <= DUTY_RESET;
			secondChannelDuty_ff <= DUTY_RESET;
		end else begin
			firstChannelDuty_ff <= nxt_first_channel_duty;
			secondChannelDuty_ff <= nxt_second_channel_duty;
		end
	end

	// q24 times q16 is q40; integer part truncated, fits 16 bits while duty < 1
	// operands widened first so no product bit is lost before the slice
	assign productA = 64'(nxt_first_channel_duty) * 64'(counterPeriodMirror_ff);
	assign productB = 64'(nxt_second_channel_duty) * 64'(counterPeriodMirror_ff);
	assign scaledA = productA[CMP_MSB:CMP_LSB];
	assign scaledB = productB[CMP_MSB:CMP_LSB];

	// compare loaded on a duty write only; a later period change waits
	// for the next duty write, as the control loop rewrites duty each cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			compareAValue0_ff <= CMP_RESET;
			compareBValue0_ff <= CMP_RESET;
			compareAValue1_ff <= CMP_RESET;
		end else begin
			if (writeTaken && wordAddr == ADDR_DUTY_A) begin
				compareAValue0_ff <= scaledA;
				compareAValue1_ff <= scaledA;
			end
			if (writeTaken && wordAddr == ADDR_DUTY_B) begin
				compareBValue0_ff <= scaledB;
			end
		end
	end

	assign arrangement = ctrl_ff[CTRL_ARRANGE_BIT] ? ARR_BUCK_BOOST : ARR_DUAL_UPDOWN;

	always_comb begin
		case (arrangement)
			ARR_DUAL_UPDOWN: begin
				upDownMode = 1'b1;
				deadBandOn = 1'b0;
				partnerEnable = 1'b0;
				syncFromFirst = 1'b0;
			end
			ARR_BUCK_BOOST: begin
				upDownMode = 1'b0;
				deadBandOn = 1'b1;
				partnerEnable = 1'b1;
				syncFromFirst = 1'b1;
			end
			default: begin
				upDownMode = 1'b1;
				deadBandOn = 1'b0;
				partnerEnable = 1'b0;
				syncFromFirst = 1'b0;
			end
		endcase
	end

	// partner's b compare unused; dead band makes b from a
	assign compareB1 = CMP_RESET;

	pwm_module_core firstModule (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.enable(1'b1),
		.upDown(upDownMode),
		.master(ctrl_ff[CTRL_MASTER0_BIT]),
		.period(period_ff),
		.phase(phase0_ff),
		.compareA(compareAValue0_ff),
		.compareB(compareBValue0_ff),
		.deadBandOn(deadBandOn),
		.risingDelay(risingDelaySetting0_ff),
		.fallingDelay(fallingDelaySetting0_ff),
		.syncIn(counterSyncInput),
		.syncOut(sync0),
		.zeroEvent(zero0),
		.periodEvent(prd0),
		.counter(counter0),
		.chanA(firstOutputChannel[0]),
		.chanB(secondOutputChannel[0])
	);

	// partner follows the first module's zero event when paired
	assign sync1 = syncFromFirst ? sync0 : counterSyncInput;

	pwm_module_core partnerModule (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.enable(partnerEnable),
		.upDown(upDownMode),
		.master(ctrl_ff[CTRL_MASTER1_BIT]),
		.period(period_ff),
		.phase(phase1_ff),
		.compareA(compareAValue1_ff),
		.compareB(compareB1),
		.deadBandOn(deadBandOn),
		.risingDelay(risingDelaySetting1_ff),
		.fallingDelay(fallingDelaySetting1_ff),
		.syncIn(sync1),
		.syncOut(),
		.zeroEvent(),
		.periodEvent(),
		.counter(counter1),
		.chanA(firstOutputChannel[1]),
		.chanB(secondOutputChannel[1])
	);

	// conversion trigger only meaningful with the triangle count,
	// where zero and period mark the middle of the on or off time
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			convStart_ff <= 1'b0;
		end else begin
			convStart_ff <= upDownMode &&
				((ctrl_ff[CTRL_SOC_ZERO_BIT] && zero0) ||
				(ctrl_ff[CTRL_SOC_PRD_BIT] && prd0));
		end
	end

	assign convStart = convStart_ff;

endmodule

// *** hdl/dual_pwm_pkg.sv ***
// Purpose: shared constants and types of the dual pulse-width driver
// Assumes: 32-bit register bus, word aligned byte addresses
// Notes: all offsets, field positions and reset values live here
package dual_pwm_pkg;

	// register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PERIOD = 8'h04;
	localparam logic [7:0] ADDR_PHASE0 = 8'h08;
	localparam logic [7:0] ADDR_PHASE1 = 8'h0c;
	localparam logic [7:0] ADDR_DUTY_A = 8'h10;
	localparam logic [7:0] ADDR_DUTY_B = 8'h14;
	localparam logic [7:0] ADDR_RISE0 = 8'h18;
	localparam logic [7:0] ADDR_FALL0 = 8'h1c;
	localparam logic [7:0] ADDR_RISE1 = 8'h20;
	localparam logic [7:0] ADDR_FALL1 = 8'h24;
	localparam logic [7:0] ADDR_CMP_A0 = 8'h28;
	localparam logic [7:0] ADDR_CMP_B0 = 8'h2c;
	localparam logic [7:0] ADDR_CMP_A1 = 8'h30;
	localparam logic [7:0] ADDR_COUNT = 8'h34;
	localparam logic [7:0] ADDR_PRD_MIRROR = 8'h38;

	// control register fields
	localparam int CTRL_ARRANGE_BIT = 0;
	localparam int CTRL_MASTER0_BIT = 1;
	localparam int CTRL_MASTER1_BIT = 2;
	localparam int CTRL_SOC_ZERO_BIT = 3;
	localparam int CTRL_SOC_PRD_BIT = 4;
	localparam int CTRL_WIDTH = 5;

	// fixed-point layout: duty q24 times period q16 gives q40
	localparam int DUTY_FRAC_BITS = 24;
	localparam int PERIOD_FRAC_BITS = 16;
	localparam int CMP_LSB = DUTY_FRAC_BITS + PERIOD_FRAC_BITS;
	localparam int CMP_MSB = CMP_LSB + 15;

	// reset values
	localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 5'h02;
	localparam logic [15:0] PERIOD_RESET = 16'h0064;
	localparam logic [15:0] PHASE_RESET = 16'h0000;
	localparam logic [15:0] DELAY_RESET = 16'h0000;
	localparam logic [31:0] DUTY_RESET = 32'h00000000;
	localparam logic [15:0] CMP_RESET = 16'h0000;

	typedef enum logic {ARR_DUAL_UPDOWN, ARR_BUCK_BOOST} arrangement_t;

endpackage

// *** hdl/pwm_module_core.sv ***
// Purpose: one pulse-width module: counter, compare, dead band
// Assumes: compare and delay values are stable integer settings
// Notes: outputs low and counter at zero while not enabled
`timescale 1ns/1ps
module pwm_module_core
	import dual_pwm_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// configuration
	input wire logic enable,
	input wire logic upDown,
	input wire logic master,
	input wire logic [15:0] period,
	input wire logic [15:0] phase,
	input wire logic [15:0] compareA,
	input wire logic [15:0] compareB,
	input wire logic deadBandOn,
	input wire logic [15:0] risingDelay,
	input wire logic [15:0] fallingDelay,
	// synchronisation
	input wire logic syncIn,
	output logic syncOut,
	// events and state
	output logic zeroEvent,
	output logic periodEvent,
	output logic [15:0] counter,
	// gate outputs
	output logic chanA,
	output logic chanB
);

	logic [15:0] count_ff;
	logic countUp_ff;
	logic [15:0] riseCnt_ff;
	logic [15:0] fallCnt_ff;
	logic chanA_ff;
	logic chanB_ff;
	logic rawA;
	logic rawB;

	assign counter = count_ff;
	assign zeroEvent = enable && (count_ff == 16'h0000);
	assign periodEvent = enable && (count_ff == period);
	// zero event doubles as the periodic sync to a partner module
	assign syncOut = zeroEvent;
	assign rawA = count_ff < compareA;
	assign rawB = count_ff < compareB;
	assign chanA = chanA_ff;
	assign chanB = chanB_ff;

	always_ff @(posedge core_clk) begin
		if (!rst_n || !enable) begin
			count_ff <= 16'h0000;
			countUp_ff <= 1'b1;
		end else if (!master && syncIn) begin
			// master ignores sync; slave jumps to its phase
			count_ff <= phase;
			countUp_ff <= 1'b1;
		end else if (upDown) begin
			// triangle count gives waveforms centred on the period
			if (countUp_ff) begin
				if (count_ff >= period) begin
					countUp_ff <= 1'b0;
					count_ff <= (period == 16'h0000) ? 16'h0000 : count_ff - 16'h0001;
				end else begin
					count_ff <= count_ff + 16'h0001;
				end
			end else if (count_ff == 16'h0000) begin
				countUp_ff <= 1'b1;
				count_ff <= (period == 16'h0000) ? 16'h0000 : 16'h0001;
			end else begin
				count_ff <= count_ff - 16'h0001;
			end
		end else begin
			count_ff <= (count_ff >= period) ? 16'h0000 : count_ff + 16'h0001;
		end
	end

	// time each level has been held, saturating
	always_ff @(posedge core_clk) begin
		if (!rst_n || !enable) begin
			riseCnt_ff <= 16'h0000;
			fallCnt_ff <= 16'h0000;
		end else begin
			riseCnt_ff <= !rawA ? 16'h0000 :
				(riseCnt_ff == 16'hffff) ? riseCnt_ff : riseCnt_ff + 16'h0001;
			fallCnt_ff <= rawA ? 16'h0000 :
				(fallCnt_ff == 16'hffff) ? fallCnt_ff : fallCnt_ff + 16'h0001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || !enable) begin
			chanA_ff <= 1'b0;
			chanB_ff <= 1'b0;
		end else if (deadBandOn) begin
			// a high during duty, b its complement; rising edges held back
			chanA_ff <= rawA && (riseCnt_ff >= risingDelay);
			chanB_ff <= !rawA && (fallCnt_ff >= fallingDelay);
		end else begin
			chanA_ff <= rawA;
			chanB_ff <= rawB;
		end
	end

endmodule
